// ==== core/pas_regs.svh ====
// register layout, field positions and reset values of the phase accumulator synthesizer
`ifndef PAS_REGS_SVH
`define PAS_REGS_SVH

// widths
`define PAS_ACC_WIDTH 24
`define PAS_WORD_WIDTH 24
`define PAS_PRESET_WIDTH 22
`define PAS_DEV_WIDTH 8
`define PAS_DEV_SHIFT 2
`define PAS_ENABLE_WIDTH 13
`define PAS_SINE_WIDTH 11
`define PAS_LUT_BITS 4

// latch select field of a control word
`define PAS_ADDR_MSB 23
`define PAS_ADDR_LSB 22
`define PAS_ADDR_MODE0_FREQ 2'h0
`define PAS_ADDR_MODE1_FREQ 2'h1
`define PAS_ADDR_MODE1_CTRL 2'h2
`define PAS_ADDR_MODE0_CTRL 2'h3

// frequency words
`define PAS_PRESET_MSB 21
`define PAS_PRESET_LSB 0

// mode 1 control word
`define PAS_ENABLE_MSB 12
`define PAS_ENABLE_LSB 0
`define PAS_OSC_ENABLE_BIT 11
`define PAS_DIV_SEL_BIT 13
`define PAS_MOD_SEL_BIT 16
`define PAS_ACQ_MSB 19
`define PAS_ACQ_LSB 17

// mode 0 control word
`define PAS_DEV_MSB 20
`define PAS_DEV_LSB 13

// reset values
`define PAS_PRESET_RESET 22'h000000
`define PAS_ENABLE_RESET 13'h0000
`define PAS_DEV_RESET 8'h00
`define PAS_ACQ_RESET 3'h0
`define PAS_DIV_RESET 1'h0
`define PAS_MOD_RESET 1'h0
`define PAS_ACC_RESET 24'h000000
`define PAS_SINE_MID 11'h400

`endif

// ==== core/pas_pkg.sv ====
// types shared by the phase accumulator synthesizer files
`include "pas_regs.svh"

package pas_pkg;

  // one received control word and its load pulse
  typedef struct packed {
    logic load;
    logic [`PAS_WORD_WIDTH-1:0] word;
  } pas_word_s;

  // loop settings taken from the mode 1 control word
  typedef struct packed {
    logic div_512;
    logic modulation_select_bit;
    logic [2:0] acquisition_current_factor;
  } pas_loop_cfg_s;

  // latch select field
  typedef logic [1:0] pas_addr_t;

endpackage

// ==== core/pas_serial_rx.sv ====
// three-wire serial receiver: pin synchronisers, shift register, strobe load
`timescale 1ns/1ps
`include "pas_regs.svh"

module pas_serial_rx (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // serial pins
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  input wire logic strobe_in,
  // received word
  output pas_pkg::pas_word_s word_out
);
  import pas_pkg::*;

  logic [1:0] clk_sync; // serial clock synchroniser
  logic [1:0] dat_sync; // serial data synchroniser
  logic [1:0] stb_sync; // strobe synchroniser
  logic clk_prev; // last synced serial clock
  logic stb_prev; // last synced strobe
  logic [`PAS_WORD_WIDTH-1:0] shift; // shift register
  pas_word_s result; // word and load pulse

  // two flip-flops on each pin before any logic looks at it
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      clk_sync <= 2'h0;
      dat_sync <= 2'h0;
      stb_sync <= 2'h0;
    end else begin
      clk_sync <= {clk_sync[0], serial_clock_in};
      dat_sync <= {dat_sync[0], serial_data_in};
      stb_sync <= {stb_sync[0], strobe_in};
    end
  end

  // delayed copies for edge detection on the synced levels
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      clk_prev <= 1'h0;
      stb_prev <= 1'h0;
    end else begin
      clk_prev <= clk_sync[1];
      stb_prev <= stb_sync[1];
    end
  end

  // shift in msb first; older leading bits fall off the top
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      shift <= '0;
    end else if (clk_sync[1] && !clk_prev && !stb_sync[1]) begin
      shift <= {shift[`PAS_WORD_WIDTH-2:0], dat_sync[1]};
    end
  end

  // strobe rise hands the whole word over for one cycle
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      result <= '0;
    end else begin
      result.load <= stb_sync[1] && !stb_prev;
      result.word <= shift;
    end
  end

  assign word_out = result;

endmodule

// ==== core/pas_synth.sv ====
// phase accumulator synthesizer core: setting latches, mode select, fsk, accumulator, sine table
`timescale 1ns/1ps
`include "pas_regs.svh"

module pas_synth (
  // reference clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // serial control pins
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  input wire logic strobe_in,
  // mode, modulation and loop status pins
  input wire logic mode_in,
  input wire logic tx_data_in,
  input wire logic pll_locked_in,
  // synthesizer samples
  output logic [`PAS_ACC_WIDTH-1:0] phase_out,
  output logic [`PAS_SINE_WIDTH-1:0] sine_out,
  output logic [`PAS_ACC_WIDTH-1:0] frequency_out,
  // loop and block controls
  output logic divider_512_out,
  output logic [2:0] acquisition_current_factor_out,
  output logic acquisition_pump_enable_out,
  output logic oscillator_enable_out,
  output logic [`PAS_ENABLE_WIDTH-1:0] block_enable_out
);
  import pas_pkg::*;

  pas_word_s rx_word; // word from the serial receiver
  pas_addr_t rx_addr; // latch select of that word

  // setting latches
  logic [`PAS_PRESET_WIDTH-1:0] mode0_frequency_word; // mode 0 preset
  logic [`PAS_PRESET_WIDTH-1:0] mode1_frequency_word; // mode 1 preset
  logic [`PAS_ENABLE_WIDTH-1:0] mode0_enable; // mode 0 block enables
  logic [`PAS_ENABLE_WIDTH-1:0] mode1_enable; // mode 1 block enables
  logic [`PAS_DEV_WIDTH-1:0] fsk_deviation_value; // deviation register
  pas_loop_cfg_s loop_cfg; // divider, modulation, acquisition

  // synchronised pins
  logic [1:0] mode_sync; // mode pin synchroniser
  logic [1:0] tx_sync; // transmit data synchroniser
  logic [1:0] lock_sync; // lock status synchroniser

  // datapath
  logic [`PAS_PRESET_WIDTH-1:0] preset_sel; // preset picked by mode
  logic fsk_active; // fsk modulation selected
  logic [`PAS_ACC_WIDTH-1:0] dev_term; // deviation shifted into place
  logic [`PAS_ACC_WIDTH-1:0] next_frequency; // next frequency register
  logic [`PAS_ACC_WIDTH-1:0] frequency_reg; // frequency register
  logic [`PAS_ACC_WIDTH-1:0] accumulator; // phase accumulator
  logic [`PAS_ACC_WIDTH-1:0] next_accumulator; // next phase value
  logic [`PAS_LUT_BITS+1:0] lut_phase; // top bits used for the table
  logic [`PAS_LUT_BITS-1:0] lut_index; // quarter-wave index
  logic [9:0] lut_mag; // quarter-wave magnitude
  logic [`PAS_SINE_WIDTH-1:0] next_sine; // signed-offset sample

  // quarter-wave sine magnitudes around mid scale
  localparam logic [9:0] SINE_QUARTER [0:15] = '{
    10'h032, 10'h096, 10'h0F9, 10'h159,
    10'h1B6, 10'h20E, 10'h262, 10'h2B0,
    10'h2F7, 10'h336, 10'h36E, 10'h39E,
    10'h3C4, 10'h3E1, 10'h3F5, 10'h3FE
  };

  // serial receiver for the three-wire bus
  pas_serial_rx u_serial_rx (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .serial_clock_in(serial_clock_in),
    .serial_data_in(serial_data_in),
    .strobe_in(strobe_in),
    .word_out(rx_word)
  );

  assign rx_addr = rx_word.word[`PAS_ADDR_MSB:`PAS_ADDR_LSB];

  // frequency latches; cleared only by reset, never by standby
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      mode0_frequency_word <= `PAS_PRESET_RESET;
      mode1_frequency_word <= `PAS_PRESET_RESET;
    end else if (rx_word.load) begin
      // the addressed latch alone takes the word
      case (rx_addr)
        `PAS_ADDR_MODE0_FREQ: begin
          mode0_frequency_word <= rx_word.word[`PAS_PRESET_MSB:`PAS_PRESET_LSB];
        end
        `PAS_ADDR_MODE1_FREQ: begin
          mode1_frequency_word <= rx_word.word[`PAS_PRESET_MSB:`PAS_PRESET_LSB];
        end
        default: begin
          // control words go to the other latches
        end
      endcase
    end
  end

  // control latches: enables, deviation and loop settings
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      mode0_enable <= `PAS_ENABLE_RESET;
      mode1_enable <= `PAS_ENABLE_RESET;
      fsk_deviation_value <= `PAS_DEV_RESET;
      loop_cfg.div_512 <= `PAS_DIV_RESET;
      loop_cfg.modulation_select_bit <= `PAS_MOD_RESET;
      loop_cfg.acquisition_current_factor <= `PAS_ACQ_RESET;
    end else if (rx_word.load) begin
      case (rx_addr)
        // mode 1 control word
        `PAS_ADDR_MODE1_CTRL: begin
          mode1_enable <= rx_word.word[`PAS_ENABLE_MSB:`PAS_ENABLE_LSB];
          loop_cfg.div_512 <= rx_word.word[`PAS_DIV_SEL_BIT];
          loop_cfg.modulation_select_bit <= rx_word.word[`PAS_MOD_SEL_BIT];
          loop_cfg.acquisition_current_factor <= rx_word.word[`PAS_ACQ_MSB:`PAS_ACQ_LSB];
        end
        // mode 0 control word
        `PAS_ADDR_MODE0_CTRL: begin
          mode0_enable <= rx_word.word[`PAS_ENABLE_MSB:`PAS_ENABLE_LSB];
          fsk_deviation_value <= rx_word.word[`PAS_DEV_MSB:`PAS_DEV_LSB];
        end
        default: begin
          // frequency words handled above
        end
      endcase
    end
  end

  // pins from outside the reference domain pass two flip-flops
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      mode_sync <= 2'h0;
      tx_sync <= 2'h0;
      lock_sync <= 2'h0;
    end else begin
      mode_sync <= {mode_sync[0], mode_in};
      tx_sync <= {tx_sync[0], tx_data_in};
      lock_sync <= {lock_sync[0], pll_locked_in};
    end
  end

  // preset selection and fsk deviation
  always_comb begin
    preset_sel = mode_sync[1] ? mode1_frequency_word : mode0_frequency_word;
    fsk_active = !loop_cfg.modulation_select_bit;
    dev_term = '0;
    if (fsk_active && tx_sync[1]) begin
      // deviation sits above two zero lsbs
      dev_term = {{(`PAS_ACC_WIDTH-`PAS_DEV_WIDTH-`PAS_DEV_SHIFT){1'h0}},
                  fsk_deviation_value, {`PAS_DEV_SHIFT{1'h0}}};
    end
    // two zero top bits extend the 22-bit preset to 24 bits
    next_frequency = {2'h0, preset_sel} + dev_term;
  end

  // frequency register reloads every clock, the phase is untouched
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      frequency_reg <= `PAS_ACC_RESET;
    end else begin
      frequency_reg <= next_frequency;
    end
  end

  // modular add: the carry out is dropped so the ramp wraps
  assign next_accumulator = accumulator + frequency_reg;

  // phase accumulator, one step per reference cycle
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      accumulator <= `PAS_ACC_RESET;
    end else begin
      accumulator <= next_accumulator;
    end
  end

  // quarter-wave lookup folded to a full period
  always_comb begin
    lut_phase = accumulator[`PAS_ACC_WIDTH-1:`PAS_ACC_WIDTH-`PAS_LUT_BITS-2];
    // second and fourth quarters run the table backwards
    lut_index = lut_phase[`PAS_LUT_BITS] ? ~lut_phase[`PAS_LUT_BITS-1:0]
                                         : lut_phase[`PAS_LUT_BITS-1:0];
    lut_mag = SINE_QUARTER[lut_index];
    // second half of the period lies below mid scale
    if (lut_phase[`PAS_LUT_BITS+1]) begin
      next_sine = `PAS_SINE_MID - {1'h0, lut_mag};
    end else begin
      next_sine = `PAS_SINE_MID + {1'h0, lut_mag};
    end
  end

  // sample and phase outputs to the converter
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      phase_out <= `PAS_ACC_RESET;
      sine_out <= `PAS_SINE_MID;
      frequency_out <= `PAS_ACC_RESET;
    end else begin
      phase_out <= accumulator;
      sine_out <= next_sine;
      // step = ratio x reference / 2^24 follows from this word
      frequency_out <= frequency_reg;
    end
  end

  // loop controls and per-mode enables
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      divider_512_out <= `PAS_DIV_RESET;
      acquisition_current_factor_out <= `PAS_ACQ_RESET;
      acquisition_pump_enable_out <= 1'h0;
      oscillator_enable_out <= 1'h0;
      block_enable_out <= `PAS_ENABLE_RESET;
    end else begin
      divider_512_out <= loop_cfg.div_512;
      acquisition_current_factor_out <= loop_cfg.acquisition_current_factor;
      // coarse pump runs only while lock is absent
      acquisition_pump_enable_out <= !lock_sync[1];
      // host clears this bit when an outside oscillator is used
      oscillator_enable_out <= mode_sync[1] ? mode1_enable[`PAS_OSC_ENABLE_BIT]
                                            : mode0_enable[`PAS_OSC_ENABLE_BIT];
      block_enable_out <= mode_sync[1] ? mode1_enable : mode0_enable;
    end
  end

endmodule

// ==== test/pas_host.sv ====
// host model that writes control words over the three-wire serial bus
`timescale 1ns/1ps
module pas_host (
  // reference clock
  input wire logic clock_in,
  // serial pins towards the device
  output logic serial_clock_out,
  output logic serial_data_out,
  output logic strobe_out
);
  // all lines idle low
  initial begin
    serial_clock_out = 1'h0;
    serial_data_out = 1'h0;
    strobe_out = 1'h0;
  end
  // sends 32 bits msb first; the first eight are surplus and must drop out
  task automatic send(input logic [31:0] value);
    for (int i = 31; i >= 0; i--) begin
      @(posedge clock_in);
      serial_data_out <= value[i];
      repeat (4) @(posedge clock_in);
      serial_clock_out <= 1'h1;
      repeat (4) @(posedge clock_in);
      serial_clock_out <= 1'h0;
    end
    // data and clock stay low around and during the strobe
    @(posedge clock_in);
    serial_data_out <= 1'h0;
    repeat (4) @(posedge clock_in);
    strobe_out <= 1'h1;
    repeat (4) @(posedge clock_in);
    strobe_out <= 1'h0;
    repeat (4) @(posedge clock_in);
  endtask
endmodule

// ==== test/pas_synth_asserts.sv ====
// port checker of the phase accumulator synthesizer
`timescale 1ns/1ps
`include "pas_regs.svh"
module pas_synth_asserts (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // serial, mode and status pins
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  input wire logic strobe_in,
  input wire logic mode_in,
  input wire logic tx_data_in,
  input wire logic pll_locked_in,
  // synthesizer outputs
  input wire logic [`PAS_ACC_WIDTH-1:0] phase_out,
  input wire logic [`PAS_SINE_WIDTH-1:0] sine_out,
  input wire logic [`PAS_ACC_WIDTH-1:0] frequency_out,
  input wire logic divider_512_out,
  input wire logic [2:0] acquisition_current_factor_out,
  input wire logic acquisition_pump_enable_out,
  input wire logic oscillator_enable_out,
  input wire logic [`PAS_ENABLE_WIDTH-1:0] block_enable_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  logic [3:0] since_load; // cycles since strobe high, saturating
  logic [3:0] quiet; // cycles since strobe or a pin change, saturating
  // settle counters after a load or a pin change
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      since_load <= 4'h0;
      quiet <= 4'h0;
    end else begin
      since_load <= strobe_in ? 4'h0 : since_load + {3'h0, since_load != 4'hF};
      quiet <= (strobe_in || $changed(mode_in) || $changed(tx_data_in)) ? 4'h0 :
        quiet + {3'h0, quiet != 4'hF};
    end
  end
  a_phase_step: assert property (
    frequency_out == $past(frequency_out) && frequency_out == $past(frequency_out, 2)
    |=> phase_out == $past(phase_out) + $past(frequency_out))
    else $error("phase step differs from frequency word");
  a_sine_upper: assert property (!phase_out[23] |-> sine_out >= 11'h400)
    else $error("sine below mid in first half period");
  a_sine_lower: assert property (phase_out[23] |-> sine_out <= 11'h400)
    else $error("sine above mid in second half period");
  a_pump_on: assert property (
    !pll_locked_in [*3] |=> acquisition_pump_enable_out)
    else $error("acquisition pump off while unlocked");
  a_pump_off: assert property (
    pll_locked_in [*3] |=> !acquisition_pump_enable_out)
    else $error("acquisition pump on while locked");
  a_loop_static: assert property (
    since_load > 4'h8 |-> $stable(divider_512_out) && $stable(acquisition_current_factor_out))
    else $error("loop setting changed without a load");
  a_word_static: assert property (
    quiet > 4'h8 |-> $stable(frequency_out) && $stable(block_enable_out)
    && $stable(oscillator_enable_out))
    else $error("mode outputs changed without cause");
  a_word_bound: assert property (frequency_out <= 24'h4003FB)
    else $error("frequency word above preset plus deviation range");
endmodule
bind pas_synth pas_synth_asserts chk (.clock_in, .reset_in, .serial_clock_in,
  .serial_data_in, .strobe_in, .mode_in, .tx_data_in, .pll_locked_in, .phase_out,
  .sine_out, .frequency_out, .divider_512_out, .acquisition_current_factor_out,
  .acquisition_pump_enable_out, .oscillator_enable_out, .block_enable_out);

// ==== test/pas_synth_tb.sv ====
// self-checking bench of the phase accumulator synthesizer
`timescale 1ns/1ps
`include "pas_regs.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s expected %0h seen %0h", n, e, g); end end
module pas_synth_tb;
  import pas_pkg::*;
  logic clock_in = 1'h0; // reference clock
  logic reset_in = 1'h1; // held for two cycles
  logic mode_in = 1'h0; // mode pin
  logic tx_data_in = 1'h0; // transmit data pin
  logic pll_locked_in = 1'h0; // loop lock status pin
  wire logic serial_clock_in;
  wire logic serial_data_in;
  wire logic strobe_in;
  logic [23:0] phase_out;
  logic [10:0] sine_out;
  logic [23:0] frequency_out;
  logic divider_512_out;
  logic [2:0] acquisition_current_factor_out;
  logic acquisition_pump_enable_out;
  logic oscillator_enable_out;
  logic [12:0] block_enable_out;
  int mismatches = 0;
  int num_checks = 0;
  int words [4]; // model copies of the four latches, by address
  // 100 MHz clock
  always #5 clock_in = ~clock_in;
  pas_host host (.clock_in, .serial_clock_out(serial_clock_in),
    .serial_data_out(serial_data_in), .strobe_out(strobe_in));
  pas_synth uut (.clock_in, .reset_in, .serial_clock_in, .serial_data_in, .strobe_in,
    .mode_in, .tx_data_in, .pll_locked_in, .phase_out, .sine_out, .frequency_out,
    .divider_512_out, .acquisition_current_factor_out, .acquisition_pump_enable_out,
    .oscillator_enable_out, .block_enable_out);
  // expected frequency word for a mode and transmit level
  function automatic int exp_freq(int m, int t);
    int p;
    p = words[m] & 32'h3FFFFF;
    if (((words[2] >> 16) & 1) == 0 && t == 1) p += ((words[3] >> 13) & 32'hFF) * 4;
    return p;
  endfunction
  // prints the counts and the verdict, then stops
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // writes one latch with random surplus leading bits
  task automatic write(input int addr, input int value);
    logic [31:0] w;
    w = {8'($urandom), 2'(addr), 22'(value)};
    words[addr] = int'(w[23:0]);
    host.send(w);
  endtask
  // walks both modes and both transmit levels against the model
  task automatic check_all(input string name);
    int ctrl;
    logic [23:0] p0;
    real d; // sine error against the ideal curve
    for (int m = 0; m < 2; m++) begin
      for (int t = 0; t < 2; t++) begin
        @(posedge clock_in);
        mode_in <= 1'(m);
        tx_data_in <= 1'(t);
        repeat (10) @(posedge clock_in);
        @(negedge clock_in);
        ctrl = m ? words[2] : words[3];
        `CHK("frequency", 24'(exp_freq(m, t)), frequency_out)
        `CHK("enables", 13'(ctrl), block_enable_out)
        `CHK("oscillator", 1'(ctrl >> 11), oscillator_enable_out)
        `CHK("divider", 1'(words[2] >> 13), divider_512_out)
        `CHK("acquisition", 3'(words[2] >> 17), acquisition_current_factor_out)
        p0 = phase_out;
        repeat (50) @(negedge clock_in);
        `CHK("phase", 24'(p0 + 50 * exp_freq(m, t)), phase_out)
        // ideal sample at the middle of the segment, one of 64 per period, amplitude 1023 about mid scale
        d = $itor(sine_out) - 1024.0 -
          1023.0 * $sin(3.14159265358979 * (2.0 * $itor(phase_out[23:18]) + 1.0) / 64.0);
        `CHK("sine", 1'h1, (d < 2.0 && d > -2.0))
      end
    end
    $display("test %s done", name);
  endtask
  // watchdog well beyond the expected run of about 2600 cycles
  initial begin
    repeat (30000) @(posedge clock_in);
    mismatches++;
    results();
  end
  // main sequence
  initial begin
    void'($urandom(68));
    repeat (2) @(posedge clock_in);
    reset_in <= 1'h0;
    write(0, $urandom);
    write(1, $urandom);
    write(2, $urandom | 32'h12000); // fsk off, divide by 512
    write(3, $urandom);
    check_all("presets");
    // fsk on, divide by 256, oscillator bit cleared as for an outside source
    write(2, $urandom & ~32'h12800);
    write(3, $urandom | 32'h1FE000); // full deviation
    write(0, 32'h3FFFFF); // largest preset
    check_all("fsk");
    @(posedge clock_in);
    pll_locked_in <= 1'h1;
    repeat (6) @(negedge clock_in);
    `CHK("pump locked", 1'h0, acquisition_pump_enable_out)
    // lock is dropped on a rising edge like every other input
    @(posedge clock_in);
    pll_locked_in <= 1'h0;
    repeat (6) @(negedge clock_in);
    `CHK("pump unlocked", 1'h1, acquisition_pump_enable_out)
    $display("test lock done");
    results();
  end
endmodule
